// ===== hw/charger_cfg_pkg.sv
// Constants, field layouts and carrier types for the charger parameter registers.
// Assumes a 125 MHz sys_clk and a serial-bus engine that hands over byte accesses.
// What this block does
// - Precharge current code sits in first register bits 7:4, 60 mA steps, default 0010.
// - Precharge code written above 1100 is stored as 1100.
// - Termination current code sits in first register bits 3:0, default 0010.
// - Termination code above 1100 (780 mA) is stored as 1100.
// - Charge voltage code, second register 7:3, 3.856 V plus 32 mV steps, default 01011.
// - Charge voltage code 01111 selects 4.352 V instead of the linear value.
// - Charge voltage code above 11000 is stored as 11000.
// - Third register bit 7 enables termination, default 1.
// - Third register bit 6 turns the protection switch off, only while high impedance is on.
// - Third register 5:4 picks host timeout: off, 40 s, 80 s, 160 s; default 01.
// - Third register bit 3 enables both safety timers, default 1.
// - Third register bit 2 picks safety timer length 5 h or 10 h, default 1.
// - Fourth register bits 7:6 pick overvoltage threshold 5.5/6.5/10.5/14 V, default 01.
// - Fourth register 3:0: input voltage floor, 3.9 V plus 100 mV steps, default 0110.
// - Register reset restores all four registers; host timeout restores only the first three.
// - The timeout restart request clears itself once the timer has restarted.
package charger_cfg_pkg;

    localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_ADDR = 8'h03;
    localparam logic [7:0] CHARGE_VOLTAGE_RECHARGE_ADDR = 8'h04;
    localparam logic [7:0] TERMINATION_TIMER_CONTROL_ADDR = 8'h05;
    localparam logic [7:0] INPUT_PROTECTION_FLOOR_ADDR = 8'h06;

    // Reset values
    localparam logic [7:0] PRECHARGE_TERMINATION_CURRENT_RST = 8'h22;
    localparam logic [7:0] CHARGE_VOLTAGE_RECHARGE_RST = 8'h58;
    localparam logic [7:0] TERMINATION_TIMER_CONTROL_RST = 8'h9E;
    localparam logic [7:0] INPUT_PROTECTION_FLOOR_RST = 8'h46;

    // Implemented bits; everything else is reserved
    localparam logic [7:0] CHARGE_VOLTAGE_RECHARGE_MASK = 8'hF9;
    localparam logic [7:0] TERMINATION_TIMER_CONTROL_MASK = 8'hFE;
    localparam logic [7:0] INPUT_PROTECTION_FLOOR_MASK = 8'hCF;

    // Field positions
    localparam int PRECHARGE_LSB = 4;
    localparam int TERMINATION_LSB = 0;
    localparam int CHARGE_VOLTAGE_LSB = 3;
    localparam int RECHARGE_BIT = 0;
    localparam int TERM_ENABLE_BIT = 7;
    localparam int PROTECT_OFF_BIT = 6;
    localparam int TIMEOUT_SEL_LSB = 4;
    localparam int SAFETY_ENABLE_BIT = 3;
    localparam int SAFETY_LENGTH_BIT = 2;
    localparam int THERMAL_BIT = 1;
    localparam int OVERVOLTAGE_LSB = 6;
    localparam int VOLTAGE_FLOOR_LSB = 0;

    // Clamp limits and the special voltage code
    localparam logic [4:0] CURRENT_CODE_MAX = 5'h0C;
    localparam logic [4:0] CHARGE_VOLTAGE_MAX = 5'h18;
    localparam logic [4:0] CHARGE_VOLTAGE_SPECIAL = 5'h0F;
    localparam logic [12:0] CHARGE_VOLTAGE_OFFSET_MV = 13'd3856;
    localparam logic [12:0] CHARGE_VOLTAGE_STEP_MV = 13'd32;
    localparam logic [12:0] CHARGE_VOLTAGE_SPECIAL_MV = 13'd4352;

    // Host timeout periods in seconds, by select code
    localparam logic [7:0] TIMEOUT_40_S = 8'd40;
    localparam logic [7:0] TIMEOUT_80_S = 8'd80;
    localparam logic [7:0] TIMEOUT_160_S = 8'd160;

    // One-second prescaler
    localparam longint ONE_SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 8;
    localparam int SECOND_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic [3:0] precharge_current_code;
        logic [3:0] termination_current_code;
        logic [4:0] charge_voltage_code;
        logic [12:0] charge_voltage_mv;
        logic recharge_offset_select;
        logic termination_enable;
        logic input_protect_switch_off;
        logic [1:0] host_timeout_select;
        logic safety_timer_enable;
        logic safety_timer_length;
        logic thermal_limit_select;
        logic [1:0] input_overvoltage_threshold;
        logic [3:0] input_voltage_floor;
    } config_type;

    typedef struct packed {
        logic [7:0] prechg_term;
        logic [7:0] charge_voltage_code_rechg;
        logic [7:0] term_timer;
        logic [7:0] protect_floor;
        logic [26:0] tick_cnt;
        logic [7:0] sec_cnt;
        logic restart_pend;
        logic expired;
        logic [7:0] rdata;
        logic rvalid;
    } state_type;

endpackage

// ===== hw/charger_param_config_regs.sv
// Four configuration registers of the charger with clamping, decode and host timeout.
// Assumes the serial-bus engine presents single-cycle byte accesses on sys_clk.
`timescale 1ns/1ns
module charger_param_config_regs
    import charger_cfg_pkg::*;
#(
    parameter int SEC_CYCLES_P = SECOND_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register access from the serial-bus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // Reset sources and timeout control
    input wire logic reg_rst,
    input wire logic host_timeout_restart,
    output logic host_timeout_restart_pending,
    output logic host_timeout_expired,
    // Charger state that qualifies the decode
    input wire logic input_high_impedance,
    // Settings to the charger core
    output config_type cfg
);

    state_type state_q;
    state_type state_d;
    logic [7:0] period_s;
    logic timeout_hit;
    logic tick_wrap;

    function automatic logic [4:0] clamp_code(input logic [4:0] v, input logic [4:0] lim);
        clamp_code = (v > lim) ? lim : v;
    endfunction

    function automatic logic [7:0] timeout_seconds(input logic [1:0] sel);
        case (sel)
            2'h1: timeout_seconds = TIMEOUT_40_S;
            2'h2: timeout_seconds = TIMEOUT_80_S;
            2'h3: timeout_seconds = TIMEOUT_160_S;
            default: timeout_seconds = 8'h00;
        endcase
    endfunction

    assign period_s = timeout_seconds(state_q.term_timer[TIMEOUT_SEL_LSB +: 2]);
    assign tick_wrap = (state_q.tick_cnt == 27'(SEC_CYCLES_P - 1));
    assign timeout_hit = (period_s != 8'h00) && !state_q.restart_pend && tick_wrap &&
                         ((state_q.sec_cnt + 8'h01) == period_s);

    always_comb begin
        state_d = state_q;
        state_d.expired = 1'b0;
        state_d.rvalid = reg_rd;
        state_d.rdata = 8'h00;

        // Writes store the clamped code so read-back matches what is applied
        if (reg_wr) begin
            case (reg_addr)
                PRECHARGE_TERMINATION_CURRENT_ADDR: begin
                    state_d.prechg_term[PRECHARGE_LSB +: 4] =
                        4'(clamp_code({1'b0, reg_wdata[PRECHARGE_LSB +: 4]},
                                      CURRENT_CODE_MAX));
                    state_d.prechg_term[TERMINATION_LSB +: 4] =
                        4'(clamp_code({1'b0, reg_wdata[TERMINATION_LSB +: 4]},
                                      CURRENT_CODE_MAX));
                end
                CHARGE_VOLTAGE_RECHARGE_ADDR: begin
                    state_d.charge_voltage_code_rechg = reg_wdata & CHARGE_VOLTAGE_RECHARGE_MASK;
                    state_d.charge_voltage_code_rechg[CHARGE_VOLTAGE_LSB +: 5] =
                        clamp_code(reg_wdata[CHARGE_VOLTAGE_LSB +: 5],
                                   CHARGE_VOLTAGE_MAX);
                end
                TERMINATION_TIMER_CONTROL_ADDR: begin
                    state_d.term_timer = reg_wdata & TERMINATION_TIMER_CONTROL_MASK;
                end
                INPUT_PROTECTION_FLOOR_ADDR: begin
                    state_d.protect_floor = reg_wdata & INPUT_PROTECTION_FLOOR_MASK;
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                PRECHARGE_TERMINATION_CURRENT_ADDR: state_d.rdata = state_q.prechg_term;
                CHARGE_VOLTAGE_RECHARGE_ADDR: state_d.rdata = state_q.charge_voltage_code_rechg;
                TERMINATION_TIMER_CONTROL_ADDR: state_d.rdata = state_q.term_timer;
                INPUT_PROTECTION_FLOOR_ADDR: state_d.rdata = state_q.protect_floor;
                default: state_d.rdata = 8'h00;
            endcase
        end

        // Host timeout timer: a one-second prescaler feeding a seconds counter
        if (period_s == 8'h00) begin
            state_d.tick_cnt = 27'h0;
            state_d.sec_cnt = 8'h00;
        end else if (tick_wrap) begin
            state_d.tick_cnt = 27'h0;
            state_d.sec_cnt = state_q.sec_cnt + 8'h01;
        end else begin
            state_d.tick_cnt = state_q.tick_cnt + 27'h1;
        end

        // Restart clears the timer, then the request drops; a new request wins
        if (state_q.restart_pend) begin
            state_d.tick_cnt = 27'h0;
            state_d.sec_cnt = 8'h00;
        end
        state_d.restart_pend = host_timeout_restart;

        // Resets override a write in the same cycle
        if (timeout_hit) begin
            state_d.prechg_term = PRECHARGE_TERMINATION_CURRENT_RST;
            state_d.charge_voltage_code_rechg = CHARGE_VOLTAGE_RECHARGE_RST;
            state_d.term_timer = TERMINATION_TIMER_CONTROL_RST;
            state_d.tick_cnt = 27'h0;
            state_d.sec_cnt = 8'h00;
            state_d.expired = 1'b1;
        end
        if (reg_rst) begin
            state_d.prechg_term = PRECHARGE_TERMINATION_CURRENT_RST;
            state_d.charge_voltage_code_rechg = CHARGE_VOLTAGE_RECHARGE_RST;
            state_d.term_timer = TERMINATION_TIMER_CONTROL_RST;
            state_d.protect_floor = INPUT_PROTECTION_FLOOR_RST;
            state_d.tick_cnt = 27'h0;
            state_d.sec_cnt = 8'h00;
            state_d.restart_pend = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '{prechg_term: PRECHARGE_TERMINATION_CURRENT_RST,
                         charge_voltage_code_rechg: CHARGE_VOLTAGE_RECHARGE_RST,
                         term_timer: TERMINATION_TIMER_CONTROL_RST,
                         protect_floor: INPUT_PROTECTION_FLOOR_RST,
                         default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign reg_rd_valid = state_q.rvalid;
    assign host_timeout_restart_pending = state_q.restart_pend;
    assign host_timeout_expired = state_q.expired;

    always_comb begin
        cfg.precharge_current_code = state_q.prechg_term[PRECHARGE_LSB +: 4];
        cfg.termination_current_code = state_q.prechg_term[TERMINATION_LSB +: 4];
        cfg.charge_voltage_code = state_q.charge_voltage_code_rechg[CHARGE_VOLTAGE_LSB +: 5];
        // The linear sum at 01111 would give 4.336 V; that code is remapped
        if (cfg.charge_voltage_code == CHARGE_VOLTAGE_SPECIAL) begin
            cfg.charge_voltage_mv = CHARGE_VOLTAGE_SPECIAL_MV;
        end else begin
            cfg.charge_voltage_mv = 13'(CHARGE_VOLTAGE_OFFSET_MV +
                CHARGE_VOLTAGE_STEP_MV * {8'h00, cfg.charge_voltage_code});
        end
        cfg.recharge_offset_select = state_q.charge_voltage_code_rechg[RECHARGE_BIT];
        cfg.termination_enable = state_q.term_timer[TERM_ENABLE_BIT];
        cfg.input_protect_switch_off = state_q.term_timer[PROTECT_OFF_BIT] &&
                                       input_high_impedance;
        cfg.host_timeout_select = state_q.term_timer[TIMEOUT_SEL_LSB +: 2];
        cfg.safety_timer_enable = state_q.term_timer[SAFETY_ENABLE_BIT];
        cfg.safety_timer_length = state_q.term_timer[SAFETY_LENGTH_BIT];
        cfg.thermal_limit_select = state_q.term_timer[THERMAL_BIT];
        cfg.input_overvoltage_threshold = state_q.protect_floor[OVERVOLTAGE_LSB +: 2];
        cfg.input_voltage_floor = state_q.protect_floor[VOLTAGE_FLOOR_LSB +: 4];
    end

    sequence s_quiet_reset;
        !reg_rst && !timeout_hit;
    endsequence

    sequence s_write_to(logic [7:0] a);
        reg_wr && (reg_addr == a) ##0 s_quiet_reset;
    endsequence

    a_prechg_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_write_to(PRECHARGE_TERMINATION_CURRENT_ADDR) ##0 (reg_wdata[7:4] > 4'hC)
        |=> cfg.precharge_current_code == 4'hC)
        else $error("precharge code not clamped");

    a_term_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_write_to(PRECHARGE_TERMINATION_CURRENT_ADDR)
        |=> cfg.termination_current_code ==
            ($past(reg_wdata[3:0]) > 4'hC ? 4'hC : $past(reg_wdata[3:0])))
        else $error("termination code not stored or clamped");

    a_charge_voltage_code_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_write_to(CHARGE_VOLTAGE_RECHARGE_ADDR) ##0 (reg_wdata[7:3] > 5'h18)
        |=> cfg.charge_voltage_code == 5'h18 && cfg.charge_voltage_mv == 13'd4624)
        else $error("charge voltage not clamped");

    a_charge_voltage_code_special: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cfg.charge_voltage_code == 5'h0F) |-> cfg.charge_voltage_mv == 13'd4352)
        else $error("special charge voltage not applied");

    a_protect_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg.input_protect_switch_off |-> input_high_impedance && state_q.term_timer[6])
        else $error("protection switch off without high impedance");

    a_cmd_reset_all: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rst |=> state_q.protect_floor == 8'h46 && state_q.prechg_term == 8'h22 &&
                    state_q.charge_voltage_code_rechg == 8'h58 &&
                    state_q.term_timer == 8'h9E ##1 1'b1)
        else $error("register reset did not restore defaults");

    a_timeout_keeps_floor: assert property (@(posedge sys_clk) disable iff (!rstn)
        timeout_hit && !reg_rst && !reg_wr
        |=> host_timeout_expired && state_q.charge_voltage_code_rechg == 8'h58 &&
            $stable(state_q.protect_floor))
        else $error("timeout reset wrong register set");

    a_timeout_period: assert property (@(posedge sys_clk) disable iff (!rstn)
        timeout_hit |-> state_q.sec_cnt == period_s - 8'h01 && period_s != 8'h00)
        else $error("timeout fired at wrong second");

    a_restart_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        state_q.restart_pend && !reg_rst && !host_timeout_restart
        |=> !state_q.restart_pend && state_q.tick_cnt == 27'h0)
        else $error("restart request did not self clear");

    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd_valid |-> (state_q.charge_voltage_code_rechg[2:1] == 2'b00) &&
                         !state_q.term_timer[0] && (state_q.protect_floor[5:4] == 2'b00))
        else $error("reserved bit set");

endmodule // charger_param_config_regs

// ===== verif/host_bus_model.sv
// Host model: byte reads and writes, timeout restart and register-reset pulses.
// Assumes the design samples on rising sys_clk; this model drives on falling edges.
`timescale 1ns/1ns
module host_bus_model (
    // Clock
    input wire logic sys_clk,
    // Register access
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    // Reset and timeout control
    output logic reg_rst,
    output logic host_timeout_restart
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_rst = 1'b0;
        host_timeout_restart = 1'b0;
    end

    // Released lines show the inverse so a stale value is never mistaken for live data
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(negedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge sys_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(negedge sys_clk);
        data = reg_rdata;
        ok = reg_rd_valid;
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
    endtask

    // Called by the bench well inside the chosen period to hold off the timeout reset
    task automatic pulse_restart;
        @(negedge sys_clk);
        host_timeout_restart <= 1'b1;
        @(negedge sys_clk);
        host_timeout_restart <= 1'b0;
    endtask

    task automatic pulse_reset;
        @(negedge sys_clk);
        reg_rst <= 1'b1;
        @(negedge sys_clk);
        reg_rst <= 1'b0;
    endtask
endmodule // host_bus_model

// ===== verif/tb.sv
// Self-checking bench for the charger parameter registers.
// Assumes the host model drives the bus; prescaler shortened to four cycles a second.
`timescale 1ns/1ns
module tb;
    import charger_cfg_pkg::*;
    localparam int SEC_P = 4;
    logic sys_clk, rstn, hiz, wr, rd, rd_valid, rst_cmd, restart, pending, expired;
    logic [7:0] addr, wdata, rdata;
    config_type cfg;
    int err_count, check_count, n, exp_base, exp_count;
    int periods[3] = '{40, 80, 160};
    logic [4:0] vc;
    logic [12:0] mv;

    charger_param_config_regs #(.SEC_CYCLES_P(SEC_P)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rd_valid(rd_valid), .reg_rst(rst_cmd), .host_timeout_restart(restart),
        .host_timeout_restart_pending(pending), .host_timeout_expired(expired),
        .input_high_impedance(hiz), .cfg(cfg));
    host_bus_model u_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_rst(rst_cmd),
        .host_timeout_restart(restart));

    task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string what);
        check_count++;
        if (seen !== expd) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, expd);
        end
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] expd);
        logic [7:0] d;
        logic v;
        u_host.read_reg(a, d, v);
        check({15'h0, v}, 16'h1, "read strobe");
        check({8'h00, d}, {8'h00, expd}, "read data");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Expiry pulses are counted mid-cycle, where the registered pulse has settled
    always @(negedge sys_clk) begin
        if (expired) begin
            exp_count++;
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("wrong value at %0t: watchdog ran out", $time);
        summarize();
    end

    initial begin
        rstn = 1'b0;
        hiz = 1'b0;
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        expect_reg(8'h03, 8'h22);
        expect_reg(8'h04, 8'h58);
        expect_reg(8'h05, 8'h9E);
        expect_reg(8'h06, 8'h46);
        check({3'h0, cfg.charge_voltage_mv}, 16'd4208, "default voltage");
        u_host.write_reg(8'h05, 8'hCF);
        expect_reg(8'h05, 8'hCE);
        u_host.write_reg(8'h07, 8'hFF);
        expect_reg(8'h07, 8'h00);
        $display("test defaults done");
        u_host.write_reg(8'h03, 8'hDC);
        expect_reg(8'h03, 8'hCC);
        u_host.write_reg(8'h03, 8'hBF);
        expect_reg(8'h03, 8'hBC);
        check({8'h00, cfg.precharge_current_code, cfg.termination_current_code}, 16'hBC, "cur");
        foreach (periods[i]) begin
            vc = (i == 0) ? 5'h00 : (i == 1) ? 5'h0F : 5'h1F;
            u_host.write_reg(8'h04, {vc, 3'b111});
            if (vc > CHARGE_VOLTAGE_MAX) vc = CHARGE_VOLTAGE_MAX;
            mv = (vc == 5'h0F) ? 13'd4352 : 13'd3856 + 13'd32 * vc;
            expect_reg(8'h04, {vc, 3'b001});
            check({3'h0, cfg.charge_voltage_mv}, {3'h0, mv}, "voltage");
            check({15'h0, cfg.recharge_offset_select}, 16'h1, "recharge select");
        end
        for (int t = 0; t < 4; t++) begin
            u_host.write_reg(8'h06, {t[1:0], 2'b11, 2'b10, t[1:0]});
            expect_reg(8'h06, {t[1:0], 2'b00, 2'b10, t[1:0]});
            check({14'h0, cfg.input_overvoltage_threshold}, {14'h0, t[1:0]}, "ovp");
            check({12'h0, cfg.input_voltage_floor}, {12'h0, 2'b10, t[1:0]}, "floor");
        end
        u_host.write_reg(8'h05, 8'h48);
        check({8'h00, cfg.termination_enable, cfg.input_protect_switch_off,
            cfg.host_timeout_select, cfg.safety_timer_enable, cfg.safety_timer_length,
            cfg.thermal_limit_select, 1'b0}, 16'h0008, "ctl no hiz");
        hiz = 1'b1;
        @(negedge sys_clk);
        check({15'h0, cfg.input_protect_switch_off}, 16'h1, "ctl hiz");
        u_host.write_reg(8'h05, 8'h84);
        check({8'h00, cfg.termination_enable, cfg.safety_timer_enable, cfg.safety_timer_length,
            5'h00}, 16'h00A0, "ctl bits");
        $display("test fields done");
        foreach (periods[i]) begin
            u_host.write_reg(8'h03, 8'h55);
            u_host.write_reg(8'h06, 8'h0A);
            u_host.write_reg(8'h05, {2'b10, 2'(i + 1), 4'hE});
            u_host.pulse_restart();
            check({15'h0, pending}, 16'h1, "pending set");
            n = 0;
            while (n < 800 && expired !== 1'b1) begin
                @(negedge sys_clk);
                n++;
            end
            check({15'h0, 1'(n >= periods[i] * SEC_P - 2 && n <= periods[i] * SEC_P + 3)},
                16'h1, "timeout span");
            expect_reg(8'h03, 8'h22);
            expect_reg(8'h04, 8'h58);
            expect_reg(8'h05, 8'h9E);
            expect_reg(8'h06, 8'h0A);
        end
        u_host.pulse_restart();
        @(negedge sys_clk);
        check({15'h0, pending}, 16'h0, "pending clear");
        exp_base = exp_count;
        repeat (5) begin
            repeat (100) @(negedge sys_clk);
            u_host.pulse_restart();
        end
        u_host.write_reg(8'h05, 8'h8E);
        repeat (700) @(negedge sys_clk);
        check({15'h0, 1'(exp_count == exp_base)}, 16'h1, "no expiry");
        $display("test timeout done");
        u_host.write_reg(8'h04, 8'h79);
        u_host.write_reg(8'h06, 8'h8F);
        u_host.pulse_reset();
        expect_reg(8'h03, 8'h22);
        expect_reg(8'h04, 8'h58);
        expect_reg(8'h05, 8'h9E);
        expect_reg(8'h06, 8'h46);
        $display("test register reset done");
        summarize();
    end
endmodule // tb
